//--- bench/lccf_phy_model.sv
module lccf_phy_model (
	input wire logic clk,
	output logic root,
	output logic phy_v,
	output logic sid_v,
	output logic cs_v,
	output logic [11:0] cs_off
);
	timeunit 1ns;
	timeprecision 1ns;
	initial
	begin
		root = 1'b1;
		phy_v = 1'b0;
		sid_v = 1'b0;
		cs_v = 1'b0;
		cs_off = 12'h000;
	end
	task automatic pkt(input logic phy, input logic sid);
		@(posedge clk);
		phy_v <= phy;
		sid_v <= sid;
		@(posedge clk);
		phy_v <= 1'b0;
		sid_v <= 1'b0;
	endtask : pkt
	// The offset field is inverted once the pulse ends so a stale value never passes.
	task automatic cstart(input logic [11:0] off);
		@(posedge clk);
		cs_v <= 1'b1;
		cs_off <= off;
		@(posedge clk);
		cs_v <= 1'b0;
		cs_off <= ~off;
	endtask : cstart
	task automatic set_root(input logic r);
		root <= r;
	endtask : set_root
endmodule : lccf_phy_model

//--- bench/lccf_tb.sv
module lccf_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int P = 8;
	localparam logic [31:0] A_S = 32'h0000_00e0;
	localparam logic [31:0] A_C = 32'h0000_00e4;
	logic clk = 1'b0, rst = 1'b1, hwrite = 1'b0, tick = 1'b0, ext = 1'b0, flag = 1'b0;
	logic ctx = 1'b0, hready, hresp, tx, ps, pd, ss, sd, root, pv, sv, cv;
	logic [31:0] haddr = '0, hwdata = '0, hrdata, rd, refc = '0, seed = 32'hbbb5_95db;
	logic [1:0] htrans = 2'h0;
	logic [11:0] coff, off;
	int err_total = 0, comparisons = 0, cyc = 0, ntx = 0, nps = 0, npd = 0, nss = 0, nsd = 0;
	int eps = 0, epd = 0, ess = 0, esd = 0;
	lccf_top #(.PERIOD(P)) i_lccf_top (.CLK(clk), .RESET(rst), .HSEL(1'b1), .HADDR(haddr),
		.HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready),
		.HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp), .CYCLE_TICK(tick),
		.EXTERNAL_CYCLE_INPUT(ext), .IS_ROOT(root), .OVERLONG_CYCLE_FLAG(flag),
		.RX_CYCLE_START_VALID(cv), .RX_CYCLE_START_OFFSET(off),
		.ASYNCHRONOUS_RECEIVE_REQ_ENABLE(ctx), .PHY_PACKET_VALID(pv), .SELF_ID_PACKET_VALID(sv),
		.CYCLE_OFFSET(coff), .CYCLE_START_TX(tx), .PHY_PACKET_STORE(ps),
		.PHY_PACKET_DISCARD(pd), .SELF_ID_PACKET_STORE(ss), .SELF_ID_PACKET_DISCARD(sd));
	lccf_phy_model i_lccf_phy_model (.clk(clk), .root(root), .phy_v(pv), .sid_v(sv),
		.cs_v(cv), .cs_off(off));
	always #25 clk = ~clk;
	always @(posedge clk)
	begin
		cyc++;
		if (tx === 1'b1) ntx++;
		if (ps === 1'b1) nps++;
		if (pd === 1'b1) npd++;
		if (ss === 1'b1) nss++;
		if (sd === 1'b1) nsd++;
		if (cyc == 5000)
		begin
			err_total++;
			results();
		end
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	task automatic results();
		if (err_total == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : results
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e)
		begin
			err_total++;
			$display("FAIL %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	// The reference copy follows each write; a blocked generator set stays out of it.
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge clk);
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		@(posedge clk);
		while (hready !== 1'b1) @(posedge clk);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge clk);
		while (hready !== 1'b1) @(posedge clk);
		rd = hrdata;
		chk("hresp", hresp, 0);
		if (w && a == A_S)
			refc = refc | (d & 32'h0070_0600 & (flag ? 32'hffdf_ffff : 32'hffff_ffff));
		if (w && a == A_C)
			refc = refc & ~d;
	endtask : bus
	task automatic tk(input int n);
		repeat (n)
		begin
			@(posedge clk);
			tick <= 1'b1;
			@(posedge clk);
			tick <= 1'b0;
		end
		#1;
	endtask : tk
	initial
	begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		bus(0, A_C, 0);
		chk("reset", rd, 0);
		bus(1, A_S, 32'hffff_ffff);
		bus(0, A_C, 0);
		chk("set all", rd, refc);
		bus(1, A_C, 32'h0010_0000);
		bus(0, A_S, 0);
		chk("clear", rd, refc);
		bus(1, 32'h0000_0010, 32'hffff_ffff);
		bus(0, 32'h0000_0010, 0);
		chk("unmapped", rd, 0);
		repeat (8)
		begin
			seed = lfsr(seed);
			bus(1, A_S | {seed[0], 2'b00}, seed);
			bus(0, A_S, 0);
			chk("random", rd, refc);
		end
		bus(1, A_S, 32'h0020_0000);
		flag <= 1'b1;
		refc = refc & 32'hffdf_ffff;
		repeat (3) @(posedge clk);
		bus(0, A_S, 0);
		chk("overlong clear", rd, refc);
		bus(1, A_S, 32'h0020_0000);
		bus(0, A_S, 0);
		chk("overlong block", rd, refc);
		flag <= 1'b0;
		bus(1, A_S, 32'h0020_0000);
		bus(0, A_S, 0);
		chk("set after flag", rd, refc);
		bus(1, A_C, 32'hffff_ffff);
		bus(1, A_S, 32'h0030_0000);
		for (int i = 1; i <= 10; i++)
		begin
			tk(1);
			chk("offset", coff, i % P);
		end
		repeat (3) @(posedge clk);
		chk("start tx", ntx, 1);
		bus(1, A_C, 32'h0010_0000);
		tk(3);
		chk("offset hold", coff, 10 % P);
		bus(1, A_S, 32'h0050_0000);
		tk(1);
		ext <= 1'b1;
		repeat (6) @(posedge clk);
		chk("ext rollover", coff, 0);
		chk("ext start tx", ntx, 2);
		bus(1, A_C, 32'h0020_0000);
		i_lccf_phy_model.cstart(12'h5a5);
		repeat (2) @(posedge clk);
		chk("cycle start load", coff, 12'h5a5);
		i_lccf_phy_model.set_root(1'b0);
		bus(1, A_S, 32'h0020_0000);
		ext <= 1'b0;
		repeat (4) @(posedge clk);
		ext <= 1'b1;
		repeat (6) @(posedge clk);
		chk("ext rollover again", coff, 0);
		chk("no start when not root", ntx, 2);
		// There is no self-ID buffer pointer here, so nothing must precede the accept bit.
		for (int i = 0; i < 8; i++)
		begin
			bus(1, A_C, 32'h0000_0600);
			bus(1, A_S, {21'h0, i[2:1], 9'h0});
			ctx <= i[0];
			i_lccf_phy_model.pkt(1'b1, 1'b1);
			repeat (2) @(posedge clk);
			eps += i[2] & i[0];
			epd += !(i[2] & i[0]);
			ess += i[1];
			esd += !i[1];
			chk("phy store", nps, eps);
			chk("phy discard", npd, epd);
			chk("selfid store", nss, ess);
			chk("selfid discard", nsd, esd);
		end
		results();
	end
endmodule : lccf_tb

//--- logic/lccf_cfg.svh
// Functional notes
// - Bits 31 to 23 read zero, ignore writes.
// - Bits 19-11 and 8-0 read zero.
// - Source bit one: external input rolls timer.
// - Source bit zero: roll after 3072 ticks.
// - Generator on and root: send cycle start.
// - Generator off: received cycle starts resync timer.
// - Overlong flag setting clears generator enable.
// - Generator set ignored while overlong flag set.
// - Count enable on: offset advances each tick.
// - Count enable off: offset holds, except on a received cycle start resync.
// - PHY packets stored only if accepted, context on.
// - PHY accept bit never affects self-ID packets.
// - Self-ID accept bit governs self-ID packet reception.
// - Set at lower, clear at higher address.
// - Set write sets bits written as one.
// - Clear write clears bits written as one.
`ifndef LCCF_CFG_SVH
`define LCCF_CFG_SVH

`define LCCF_ADDR_SET 8'hE0
`define LCCF_ADDR_CLEAR 8'hE4
`define LCCF_BIT_SOURCE 22
`define LCCF_BIT_GENERATOR 21
`define LCCF_BIT_COUNT 20
`define LCCF_BIT_PHY_ACCEPT 10
`define LCCF_BIT_SELFID_ACCEPT 9
`define LCCF_CTRL_MASK 32'h0070_0600
`define LCCF_CTRL_RESET 32'h0000_0000
`define LCCF_CYCLE_PERIOD 3072

`endif

//--- logic/lccf_cycle_timer.sv
`include "lccf_cfg.svh"

module lccf_cycle_timer
	import lccf_pkg::*;
#(
	parameter int PERIOD = `LCCF_CYCLE_PERIOD
)
(
	input wire logic clk,
	input wire logic reset,
	input wire logic cycle_tick,
	input wire logic count_enable,
	input wire logic source_select,
	input wire logic external_cycle_input,
	input wire logic load_valid,
	input wire logic [11:0] load_offset,
	output logic [11:0] offset,
	output logic rollover
);

	localparam logic [11:0] LAST = 12'(PERIOD - 1);

	if (PERIOD < 2 || PERIOD > 4096)
	begin : g_period_check
		$error("PERIOD must fit a 12-bit offset counter.");
	end

	lccf_timer_s st;
	lccf_timer_s next_st;
	logic ext_edge;

	always_comb
	begin
		next_st = st;
		next_st.rollover = 1'b0;
		next_st.ext_s1 = external_cycle_input;
		next_st.ext_s2 = st.ext_s1;
		next_st.ext_s3 = st.ext_s2;
		ext_edge = st.ext_s2 && !st.ext_s3;
		if (load_valid)
		begin
			next_st.offset = load_offset;
		end
		else if (count_enable)
		begin
			if (source_select)
			begin
				// The external edge wins over the tick so no edge is missed.
				if (ext_edge)
				begin
					next_st.offset = 12'h000;
					next_st.rollover = 1'b1;
				end
				else if (cycle_tick)
					next_st.offset = st.offset + 12'h001;
			end
			else if (cycle_tick)
			begin
				if (st.offset >= LAST)
				begin
					next_st.offset = 12'h000;
					next_st.rollover = 1'b1;
				end
				else
					next_st.offset = st.offset + 12'h001;
			end
		end
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			st <= '0;
		else
			st <= next_st;
	end

	assign offset = st.offset;
	assign rollover = st.rollover;

endmodule : lccf_cycle_timer

//--- logic/lccf_pkg.sv
package lccf_pkg;

	typedef struct packed {
		logic rollover_source_select;
		logic cycle_start_generator_enable;
		logic cycle_offset_count_enable;
		logic phy_packet_accept;
		logic self_identification_accept;
		logic wr_pend;
		logic wr_clear;
		logic [31:0] hrdata;
		logic hreadyout;
		logic flag_seen;
		logic cycle_start_tx;
		logic phy_store;
		logic phy_discard;
		logic selfid_store;
		logic selfid_discard;
	} lccf_state_s;

	typedef struct packed {
		logic [11:0] offset;
		logic ext_s1;
		logic ext_s2;
		logic ext_s3;
		logic rollover;
	} lccf_timer_s;

endpackage : lccf_pkg

//--- logic/lccf_top.sv
`include "lccf_cfg.svh"

module lccf_top
	import lccf_pkg::*;
#(
	parameter int PERIOD = `LCCF_CYCLE_PERIOD
)
(
	input wire logic CLK,
	input wire logic RESET,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	input wire logic CYCLE_TICK,
	input wire logic EXTERNAL_CYCLE_INPUT,
	input wire logic IS_ROOT,
	input wire logic OVERLONG_CYCLE_FLAG,
	input wire logic RX_CYCLE_START_VALID,
	input wire logic [11:0] RX_CYCLE_START_OFFSET,
	input wire logic ASYNCHRONOUS_RECEIVE_REQ_ENABLE,
	input wire logic PHY_PACKET_VALID,
	input wire logic SELF_ID_PACKET_VALID,
	output logic [11:0] CYCLE_OFFSET,
	output logic CYCLE_START_TX,
	output logic PHY_PACKET_STORE,
	output logic PHY_PACKET_DISCARD,
	output logic SELF_ID_PACKET_STORE,
	output logic SELF_ID_PACKET_DISCARD
);

	lccf_state_s st;
	lccf_state_s next_st;
	logic addr_take;
	logic rx_load;
	logic rollover;
	logic [11:0] offset;
	logic [31:0] ctrl_vec;
	logic [31:0] next_ctrl_vec;
	logic [31:0] wmask;

	function automatic logic [31:0] pack_ctrl(input lccf_state_s s);
		logic [31:0] v;
		v = `LCCF_CTRL_RESET;
		v[`LCCF_BIT_SOURCE] = s.rollover_source_select;
		v[`LCCF_BIT_GENERATOR] = s.cycle_start_generator_enable;
		v[`LCCF_BIT_COUNT] = s.cycle_offset_count_enable;
		v[`LCCF_BIT_PHY_ACCEPT] = s.phy_packet_accept;
		v[`LCCF_BIT_SELFID_ACCEPT] = s.self_identification_accept;
		return v;
	endfunction : pack_ctrl

	assign ctrl_vec = pack_ctrl(st);
	assign addr_take = HSEL && HREADY && HTRANS[1];
	// A received cycle start only steers the timer when this node does not generate them.
	assign rx_load = RX_CYCLE_START_VALID && !st.cycle_start_generator_enable;

	// The offset counter is twelve bits wide, so a longer period cannot be represented.
	if (PERIOD < 2 || PERIOD > 4096)
	begin : g_period_check
		$error("PERIOD must fit a 12-bit offset counter.");
	end

	always_comb
	begin
		next_st = st;
		next_st.hreadyout = 1'b1;
		next_st.wr_pend = 1'b0;
		// Reserved bits are masked off, so writes to them have no effect.
		wmask = HWDATA & `LCCF_CTRL_MASK;
		if (st.wr_pend)
		begin
			if (st.wr_clear)
			begin
				if (wmask[`LCCF_BIT_SOURCE])
					next_st.rollover_source_select = 1'b0;
				if (wmask[`LCCF_BIT_GENERATOR])
					next_st.cycle_start_generator_enable = 1'b0;
				if (wmask[`LCCF_BIT_COUNT])
					next_st.cycle_offset_count_enable = 1'b0;
				if (wmask[`LCCF_BIT_PHY_ACCEPT])
					next_st.phy_packet_accept = 1'b0;
				if (wmask[`LCCF_BIT_SELFID_ACCEPT])
					next_st.self_identification_accept = 1'b0;
			end
			else
			begin
				if (wmask[`LCCF_BIT_SOURCE])
					next_st.rollover_source_select = 1'b1;
				if (wmask[`LCCF_BIT_GENERATOR] && !OVERLONG_CYCLE_FLAG)
					next_st.cycle_start_generator_enable = 1'b1;
				if (wmask[`LCCF_BIT_COUNT])
					next_st.cycle_offset_count_enable = 1'b1;
				if (wmask[`LCCF_BIT_PHY_ACCEPT])
					next_st.phy_packet_accept = 1'b1;
				if (wmask[`LCCF_BIT_SELFID_ACCEPT])
					next_st.self_identification_accept = 1'b1;
			end
		end
		next_st.flag_seen = OVERLONG_CYCLE_FLAG;
		if (OVERLONG_CYCLE_FLAG && !st.flag_seen)
			next_st.cycle_start_generator_enable = 1'b0;
		next_ctrl_vec = pack_ctrl(next_st);
		if (addr_take)
		begin
			next_st.hrdata = 32'h0000_0000;
			if (HADDR[7:0] == `LCCF_ADDR_SET || HADDR[7:0] == `LCCF_ADDR_CLEAR)
			begin
				// Reading through the next value keeps a read right after a write coherent.
				if (!HWRITE)
					next_st.hrdata = next_ctrl_vec;
				else
				begin
					next_st.wr_pend = 1'b1;
					next_st.wr_clear = (HADDR[7:0] == `LCCF_ADDR_CLEAR);
				end
			end
		end
		next_st.cycle_start_tx = rollover && st.cycle_start_generator_enable && IS_ROOT;
		next_st.phy_store = PHY_PACKET_VALID && st.phy_packet_accept
			&& ASYNCHRONOUS_RECEIVE_REQ_ENABLE;
		next_st.phy_discard = PHY_PACKET_VALID && !(st.phy_packet_accept
			&& ASYNCHRONOUS_RECEIVE_REQ_ENABLE);
		next_st.selfid_store = SELF_ID_PACKET_VALID && st.self_identification_accept;
		next_st.selfid_discard = SELF_ID_PACKET_VALID && !st.self_identification_accept;
	end

	always_ff @(posedge CLK or posedge RESET)
	begin
		if (RESET)
		begin
			st <= '0;
			st.hreadyout <= 1'b1;
		end
		else
			st <= next_st;
	end

	lccf_cycle_timer #(
		.PERIOD(PERIOD)
	) u_timer (
		.clk(CLK),
		.reset(RESET),
		.cycle_tick(CYCLE_TICK),
		.count_enable(st.cycle_offset_count_enable),
		.source_select(st.rollover_source_select),
		.external_cycle_input(EXTERNAL_CYCLE_INPUT),
		.load_valid(rx_load),
		.load_offset(RX_CYCLE_START_OFFSET),
		.offset(offset),
		.rollover(rollover)
	);

	assign HRDATA = st.hrdata;
	assign HREADYOUT = st.hreadyout;
	assign HRESP = 1'b0;
	assign CYCLE_OFFSET = offset;
	assign CYCLE_START_TX = st.cycle_start_tx;
	assign PHY_PACKET_STORE = st.phy_store;
	assign PHY_PACKET_DISCARD = st.phy_discard;
	assign SELF_ID_PACKET_STORE = st.selfid_store;
	assign SELF_ID_PACKET_DISCARD = st.selfid_discard;

	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (RESET);

	rsvd_read_zero_a:
	assert property ((HRDATA & ~`LCCF_CTRL_MASK) == 32'h0000_0000)
	else $error("Reserved link control bits read non-zero.");

	set_write_bits_a:
	assert property ((st.wr_pend && !st.wr_clear) |=>
		((ctrl_vec & $past(HWDATA) & 32'h0050_0600) == ($past(HWDATA) & 32'h0050_0600)))
	else $error("Set write did not set the written bits.");

	clear_write_bits_a:
	assert property ((st.wr_pend && st.wr_clear) |=>
		((ctrl_vec & $past(HWDATA) & `LCCF_CTRL_MASK) == 32'h0000_0000))
	else $error("Clear write did not clear the written bits.");

	overlong_blocks_a:
	assert property (OVERLONG_CYCLE_FLAG |=> !st.cycle_start_generator_enable)
	else $error("Generator enable survived an overlong cycle flag.");

	start_tx_a:
	assert property (rollover |=> (CYCLE_START_TX == $past(st.cycle_start_generator_enable && IS_ROOT)))
	else $error("Cycle start packet not tied to rollover and root.");

	phy_gate_a:
	assert property (PHY_PACKET_VALID |=>
		(PHY_PACKET_STORE == $past(st.phy_packet_accept && ASYNCHRONOUS_RECEIVE_REQ_ENABLE))
		&& (PHY_PACKET_DISCARD != PHY_PACKET_STORE))
	else $error("PHY packet store or discard wrong.");

	selfid_gate_a:
	assert property (SELF_ID_PACKET_VALID |=>
		(SELF_ID_PACKET_STORE == $past(st.self_identification_accept)))
	else $error("Self-ID acceptance not governed by its own bit.");

	offset_hold_a:
	assert property ((!st.cycle_offset_count_enable && !rx_load) |=> $stable(CYCLE_OFFSET))
	else $error("Cycle offset moved while counting disabled.");

	internal_roll_a:
	assert property ((st.cycle_offset_count_enable && !st.rollover_source_select && !rx_load
		&& CYCLE_TICK && CYCLE_OFFSET == 12'(PERIOD - 1)) |=> (rollover && CYCLE_OFFSET == 12'h000))
	else $error("Internal rollover not at the last offset.");

	resync_a:
	assert property (rx_load |=> CYCLE_OFFSET == $past(RX_CYCLE_START_OFFSET))
	else $error("Received cycle start did not resync the offset.");

	// The slave never stretches a transfer, so any wait state is a fault.
	hready_okay_a:
	assert property (HREADYOUT && !HRESP)
	else $error("Slave inserted a wait state or an error response.");

	mapped_read_a:
	assert property ((addr_take && !HWRITE && (HADDR[7:0] == `LCCF_ADDR_SET
		|| HADDR[7:0] == `LCCF_ADDR_CLEAR)) |=> HRDATA == ctrl_vec)
	else $error("Read of a link control address did not return the control value.");

	unmapped_read_a:
	assert property ((addr_take && !HWRITE && HADDR[7:0] != `LCCF_ADDR_SET
		&& HADDR[7:0] != `LCCF_ADDR_CLEAR) |=> HRDATA == 32'h0000_0000)
	else $error("Read of an unmapped address returned non-zero.");

	unmapped_write_a:
	assert property ((addr_take && HWRITE && HADDR[7:0] != `LCCF_ADDR_SET
		&& HADDR[7:0] != `LCCF_ADDR_CLEAR) |=> !st.wr_pend)
	else $error("Write to an unmapped address was accepted.");

	// Bit 21 is left out of these checks, since the overlong flag may clear it at any time.
	set_keeps_bits_a:
	assert property ((st.wr_pend && !st.wr_clear) |=>
		((ctrl_vec & ~$past(HWDATA) & 32'h0050_0600)
		== ($past(ctrl_vec) & ~$past(HWDATA) & 32'h0050_0600)))
	else $error("Set write disturbed bits written as zero.");

	clear_keeps_bits_a:
	assert property ((st.wr_pend && st.wr_clear) |=>
		((ctrl_vec & ~$past(HWDATA) & 32'h0050_0600)
		== ($past(ctrl_vec) & ~$past(HWDATA) & 32'h0050_0600)))
	else $error("Clear write disturbed bits written as zero.");

	blocked_set_a:
	assert property ((OVERLONG_CYCLE_FLAG && !st.cycle_start_generator_enable)
		|=> !st.cycle_start_generator_enable)
	else $error("Generator enable was set while the overlong flag stood.");

	generator_rise_a:
	assert property ($rose(st.cycle_start_generator_enable)
		|-> $past(st.wr_pend && !st.wr_clear && !OVERLONG_CYCLE_FLAG))
	else $error("Generator enable rose without a permitted set write.");

	// Internal mode only; in external mode a synchronised edge may win over a tick.
	count_tick_a:
	assert property ((st.cycle_offset_count_enable && !st.rollover_source_select && !rx_load
		&& CYCLE_TICK && CYCLE_OFFSET < 12'(PERIOD - 1))
		|=> CYCLE_OFFSET == $past(CYCLE_OFFSET) + 12'h001)
	else $error("Cycle offset did not advance on a tick.");

	no_tick_hold_a:
	assert property ((!st.rollover_source_select && !CYCLE_TICK && !rx_load)
		|=> $stable(CYCLE_OFFSET))
	else $error("Cycle offset moved without a tick.");

	internal_roll_only_a:
	assert property ((rollover && $past(!st.rollover_source_select))
		|-> $past(CYCLE_OFFSET) >= 12'(PERIOD - 1))
	else $error("Internal rollover came before the last offset.");

	start_tx_needs_roll_a:
	assert property (CYCLE_START_TX
		|-> $past(rollover && IS_ROOT && st.cycle_start_generator_enable))
	else $error("Cycle start sent without rollover, root and generator enable.");

	ignore_rx_start_a:
	assert property ((RX_CYCLE_START_VALID && st.cycle_start_generator_enable
		&& !st.cycle_offset_count_enable) |=> $stable(CYCLE_OFFSET))
	else $error("Generator node resynced to a received cycle start.");

	selfid_one_pulse_a:
	assert property (SELF_ID_PACKET_VALID |=> (SELF_ID_PACKET_DISCARD != SELF_ID_PACKET_STORE))
	else $error("Self-ID packet neither stored nor discarded, or both.");

	idle_no_pulse_a:
	assert property ((!PHY_PACKET_VALID && !SELF_ID_PACKET_VALID) |=> !(PHY_PACKET_STORE
		|| PHY_PACKET_DISCARD || SELF_ID_PACKET_STORE || SELF_ID_PACKET_DISCARD))
	else $error("Packet pulse without an incoming packet.");

	cover_start_tx_c: cover property (CYCLE_START_TX);
	cover_resync_c: cover property (rx_load);
	cover_ext_roll_c: cover property (rollover && st.rollover_source_select);
	cover_phy_store_c: cover property (PHY_PACKET_STORE);
	cover_blocked_set_c: cover property (st.wr_pend && !st.wr_clear && OVERLONG_CYCLE_FLAG);

endmodule : lccf_top
